// ==== src/adc_cfg_pkg.sv ====
// Constants, types and decode helpers for the serial configuration port
package adc_cfg_pkg;

  // ==========================================================
  // Word and field layout
  localparam int CFG_W    = 8;  // Configuration word bits
  localparam int RES_W    = 12; // Result bits
  localparam int VEC_W    = 16; // Longest output word
  localparam int SGL_BIT  = 7;  // First bit in: single_ended_flag
  localparam int ODD_BIT  = 6;  // Odd/sign bit
  localparam int SEL_HI   = 5;  // Channel select high bit
  localparam int SEL_LO   = 4;  // Channel select low bit
  localparam int UNI_BIT  = 3;  // unipolar_select
  localparam int MSB_FIRST_SELECT_BIT = 2;  // msb_first_select
  localparam int WLH_BIT  = 1;  // word_len_hi
  localparam int WLL_BIT  = 0;  // word_len_lo, last bit in

  // ==========================================================
  // Reset values and codes
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800; // Offset to two's complement
  localparam logic [3:0]  COM_CHANNEL  = 4'h8;    // Common input as minus side
  localparam logic [1:0]  WL_8         = 2'h0;
  localparam logic [1:0]  WL_DOWN      = 2'h1;
  localparam logic [1:0]  WL_12        = 2'h2;
  localparam logic [1:0]  WL_16        = 2'h3;
  localparam logic [4:0]  LEN_8        = 5'h08;
  localparam logic [4:0]  LEN_10       = 5'h0A;
  localparam logic [4:0]  LEN_12       = 5'h0C;
  localparam logic [4:0]  LEN_16       = 5'h10;
  localparam logic [4:0]  CFG_LAST_IDX = 5'h07; // Index of last config bit
  localparam logic [4:0]  CNT_MAX      = 5'h1F; // Bit counter saturation

  // ==========================================================
  // Timing
  localparam int CLK_SYS_MHZ        = 10;
  localparam int CONVERSION_TIME_NS = 12000; // conversion_time
  localparam int CONV_CYCLES        = (CONVERSION_TIME_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam logic [7:0] CONV_LAST  = 8'(CONV_CYCLES - 1);
  localparam logic [1:0] CS_FILT_LAST = 2'h1; // Two stable edges to accept

  // ==========================================================
  // Conversion sequencer states, Gray along idle-convert-idle
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_CONVERT  = 2'b01,
    ST_SHUTDOWN = 2'b10
  } conv_state_t;

  // Output word length for a word-length code
  function automatic logic [4:0] word_len(input logic [1:0] wl);
    case (wl)
      WL_8:    word_len = LEN_8;
      WL_12:   word_len = LEN_12;
      WL_16:   word_len = LEN_16;
      default: word_len = LEN_10;
    endcase
  endfunction : word_len

  // Plus or minus input of the multiplexer for a config word
  function automatic logic [3:0] mux_channel(input logic [7:0] cfg, input logic negSide);
    if (!negSide)
      mux_channel = {1'b0, cfg[SEL_HI], cfg[SEL_LO], cfg[ODD_BIT]};
    else if (cfg[SGL_BIT])
      mux_channel = COM_CHANNEL;
    else
      mux_channel = {1'b0, cfg[SEL_HI], cfg[SEL_LO], ~cfg[ODD_BIT]};
  endfunction : mux_channel

endpackage : adc_cfg_pkg

// ==== src/shift_link_if.sv ====
// Carrier between the system-clock core and the shift-clock engine
interface shift_link_if;
  logic        frameTog;  // Flips once per recognized frame
  logic        frameOpen; // Chip select recognized low
  logic [15:0] txVec;     // Bit k is the k-th bit sent
  logic [7:0]  cfgWord;   // Captured configuration word
  logic        doneTog;   // Flips when a word ends

  modport sys (output frameTog, output frameOpen, output txVec, input cfgWord, input doneTog);
  modport link (input frameTog, input frameOpen, input txVec, output cfgWord, output doneTog);
endinterface : shift_link_if

// ==== src/serial_shift_engine.sv ====
// Shift-clock side of the port: config capture and result launch
module serial_shift_engine (
  input  wire logic   sclk,
  input  wire logic   resetn,
  input  wire logic   sdi,
  shift_link_if.link  lnk,
  output logic        sdoLine
);

  // ==========================================================
  // State on the shift clock
  logic       seenTog;   // Frame marker seen on rising edges
  logic       lnchTog;   // Frame marker seen on falling edges
  logic [4:0] bitCnt;    // Rising edges taken this frame
  logic [7:0] cfgShift;  // Incoming word, first bit ends on top
  logic       doneTogR;  // Word-end event toggle
  logic       launchBit; // Bit launched on last falling edge
  logic       newFrame;  // First rising edge of a frame
  logic [4:0] idxNow;    // Index of the bit on this edge
  logic [7:0] cfgNow;    // Config including this edge's bit
  logic [4:0] lenKnown;  // Length once the word is complete

  // Frame start is a marker change; marker is quasi-static in a frame
  assign newFrame = (lnk.frameTog != seenTog);
  assign idxNow   = newFrame ? 5'h00 : bitCnt;
  assign cfgNow   = {(newFrame ? 7'h00 : cfgShift[6:0]), sdi};
  assign lenKnown = (bitCnt > adc_cfg_pkg::CFG_LAST_IDX) ? adc_cfg_pkg::word_len(cfgShift[1:0])
                                            : adc_cfg_pkg::LEN_16;

  // ==========================================================
  // Rising edge: sample input, count bits, end word
  always_ff @(posedge sclk)
  begin
    if (!resetn)
    begin
      seenTog  <= 1'b0;
      bitCnt   <= 5'h00;
      cfgShift <= adc_cfg_pkg::CFG_RESET;
      doneTogR <= 1'b0;
    end
    else if (lnk.frameOpen)
    begin
      seenTog <= lnk.frameTog;
      if (idxNow != adc_cfg_pkg::CNT_MAX)
        bitCnt <= idxNow + 5'h01;
      // Only the first eight bits are kept, always in arrival order
      if (idxNow <= adc_cfg_pkg::CFG_LAST_IDX)
        cfgShift <= cfgNow;
      // Word end: bit count matches length from this word
      if (idxNow >= adc_cfg_pkg::CFG_LAST_IDX &&
          idxNow + 5'h01 == adc_cfg_pkg::word_len(
            (idxNow == adc_cfg_pkg::CFG_LAST_IDX) ? cfgNow[1:0] : cfgShift[1:0]))
        doneTogR <= ~doneTogR;
    end
  end

  // ==========================================================
  // Falling edge: launch next result bit, zeros past the word
  always_ff @(negedge sclk)
  begin
    if (!resetn)
    begin
      lnchTog   <= 1'b0;
      launchBit <= 1'b0;
    end
    else if (lnk.frameOpen)
    begin
      lnchTog <= lnk.frameTog;
      if (bitCnt < lenKnown && bitCnt < adc_cfg_pkg::LEN_16)
        launchBit <= lnk.txVec[bitCnt[3:0]];
      else
        launchBit <= 1'b0;
    end
  end

  // Before the first falling edge the first bit is presented
  assign sdoLine     = (lnchTog == lnk.frameTog) ? launchBit : lnk.txVec[0];
  assign lnk.cfgWord = cfgShift;
  assign lnk.doneTog = doneTogR;

endmodule : serial_shift_engine

// ==== src/adc_serial_config_port.sv ====
// Serial configuration and result port of a 12-bit eight-input converter
// Functional notes
// - Launch on falling edge, sample on rising
// - Shift out previous result while word enters
// - Take eight config bits after select recognized
// - Ignore further input until next frame
// - Start conversion at end of exchange
// - Hold result for the following frame
// - First four bits form multiplexer address
// - Differential: adjacent pair, odd bit sets polarity
// - Single-ended: select and odd bit, against common
// - Fifth bit: one unipolar, zero bipolar
// - Unipolar gives straight binary code
// - Bipolar gives two's complement code
// - Sixth bit: one MSB first, zero LSB
// - Order bit affects only outgoing data
// - Last two bits set length or shutdown
// - Filter select, recognize after two clocks
// - Sixteen-bit MSB-first ends in four zeros
// - Ignore shift clock while select high
module adc_serial_config_port (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic [11:0] rawCode,
  output logic             sdoOut,
  output logic             sdoOe,
  output logic             convStart,
  output logic             convBusy,
  output logic [3:0]       posChannel,
  output logic [3:0]       negChannel,
  output logic             unipolarMode,
  output logic             powerDown
);

  // ==========================================================
  // Declarations
  shift_link_if lnk ();                 // Carrier to shift engine
  // Clock domains: everything here runs on clk_sys; the
  // engine below runs on sclk. Frame marker and image are held
  // still for a whole frame and config from word end to the next
  // frame, so they cross as quasi-static words; only the word-end
  // event needs a toggle sync.

  logic        csMeta;                  // Select synchroniser, first stage
  logic        csSync;                  // Select synchroniser, second stage
  logic [1:0]  csFiltCnt;               // Edges the new level has held
  logic        csRecN;                  // Recognized select level
  logic        csFallPulse;             // Recognized falling select
  logic        frameTogReg;             // Frame marker to shift side
  logic [15:0] txVecReg;                // Serial image of held result
  logic [15:0] txVecNext;               // Image built from result and order
  logic        doneMeta;                // Word-end synchroniser, first stage
  logic        doneSync;                // Word-end synchroniser, second stage
  logic        doneSeen;                // Last word-end level handled
  logic        donePulse;               // One clock per finished word
  logic [7:0]  cfgReg;                  // Last accepted configuration
  logic [7:0]  cfgNew;                  // Word just finished
  logic [11:0] resultReg;               // Held, coded result
  logic [7:0]  convCnt;                 // Conversion clock counter
  adc_cfg_pkg::conv_state_t stateReg;   // Conversion sequencer
  logic        sdoLine;                 // Serial bit from the engine

  // ==========================================================
  // Select synchroniser: pin passes two flops first
  // Resets to the deselected level, so no false fall
  // is seen when reset lets go with the pin already high
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
    end
    else
    begin
      csMeta <= csN;
      csSync <= csMeta;
    end
  end

  // ==========================================================
  // Select filter: short pulses die, a change needs two clocks
  // The same filter guards both select edges; a level that
  // flips back before the count ends restarts the wait.
  // Trade-off: recognition costs three to four clocks of latency
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      csFiltCnt   <= 2'h0;
      csRecN      <= 1'b1;
      csFallPulse <= 1'b0;
    end
    else
    begin
      csFallPulse <= 1'b0;
      if (csSync == csRecN)
        csFiltCnt <= 2'h0;                 // Glitch gone, start over
      else if (csFiltCnt == adc_cfg_pkg::CS_FILT_LAST)
      begin
        csFiltCnt   <= 2'h0;
        csRecN      <= csSync;
        csFallPulse <= ~csSync;
      end
      else
        csFiltCnt <= csFiltCnt + 2'h1;
    end
  end

  // ==========================================================
  // Serial image of the held result in the held bit order
  // Bits past the twelfth stay zero, which gives the trailing
  // zeros of the long word; order comes from the held config
  always_comb
  begin
    txVecNext = 16'h0000;
    for (int k = 0; k < adc_cfg_pkg::RES_W; k++)
    begin
      if (cfgReg[adc_cfg_pkg::MSB_FIRST_SELECT_BIT])
        txVecNext[k] = resultReg[adc_cfg_pkg::RES_W - 1 - k];
      else
        txVecNext[k] = resultReg[k];
    end
  end

  // ==========================================================
  // Frame control: image loads on the same edge the marker flips
  // Enable follows the recognized level, not the pin, so a
  // select glitch never drives the data line
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      frameTogReg <= 1'b0;
      txVecReg    <= 16'h0000;
      sdoOe       <= 1'b0;
    end
    else
    begin
      sdoOe <= ~csRecN;
      if (csSync != csRecN && csFiltCnt == adc_cfg_pkg::CS_FILT_LAST && !csSync)
      begin
        // Load and flip together; shift side waits for recognition
        txVecReg    <= txVecNext;
        frameTogReg <= ~frameTogReg;
      end
    end
  end

  assign lnk.frameTog  = frameTogReg;
  assign lnk.frameOpen = ~csRecN;
  assign lnk.txVec     = txVecReg;

  // ==========================================================
  // Word-end event from the shift side, toggle then two flops
  // A toggle crosses safely whatever the shift clock rate;
  // a pulse could be missed between two system clock edges
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      doneMeta  <= 1'b0;
      doneSync  <= 1'b0;
      doneSeen  <= 1'b0;
      donePulse <= 1'b0;
    end
    else
    begin
      doneMeta  <= lnk.doneTog;
      doneSync  <= doneMeta;
      doneSeen  <= doneSync;
      donePulse <= doneSync ^ doneSeen;
    end
  end

  // Word is stable until the next frame, long after this read
  assign cfgNew = lnk.cfgWord;

  // ==========================================================
  // Accept configuration at word end
  // An abandoned frame never toggles the word end, so the
  // previous configuration stays in force
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      cfgReg <= adc_cfg_pkg::CFG_RESET;
    else if (donePulse)
      cfgReg <= cfgNew;
  end

  // ==========================================================
  // Conversion sequencer
  // Idle and convert share the start branch: a new word that
  // ends mid-conversion restarts the count with its address.
  // The counter runs conversion_time in system clock cycles
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      stateReg  <= adc_cfg_pkg::ST_IDLE;
      convCnt   <= 8'h00;
      convStart <= 1'b0;
    end
    else
    begin
      convStart <= 1'b0;
      case (stateReg)
        adc_cfg_pkg::ST_IDLE, adc_cfg_pkg::ST_CONVERT:
        begin
          if (donePulse)
          begin
            convCnt <= 8'h00;
            // Shutdown code sends no conversion request
            if (cfgNew[1:0] == adc_cfg_pkg::WL_DOWN)
              stateReg <= adc_cfg_pkg::ST_SHUTDOWN;
            else
            begin
              stateReg  <= adc_cfg_pkg::ST_CONVERT;
              convStart <= 1'b1;
            end
          end
          else if (stateReg == adc_cfg_pkg::ST_CONVERT)
          begin
            if (convCnt == adc_cfg_pkg::CONV_LAST)
              stateReg <= adc_cfg_pkg::ST_IDLE;
            else
              convCnt <= convCnt + 8'h01;
          end
        end
        adc_cfg_pkg::ST_SHUTDOWN:
        begin
          // Wakes on the next recognized select
          if (csFallPulse)
            stateReg <= adc_cfg_pkg::ST_IDLE;
        end
        default:
          stateReg <= adc_cfg_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Result capture and coding at the end of conversion time
  // Coded once at capture, so the image logic only reorders
  // bits; bipolar flips the top bit of the offset code
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      resultReg <= adc_cfg_pkg::RESULT_RESET;
    else if (stateReg == adc_cfg_pkg::ST_CONVERT && !donePulse &&
             convCnt == adc_cfg_pkg::CONV_LAST)
    begin
      if (cfgReg[adc_cfg_pkg::UNI_BIT])
        resultReg <= rawCode;
      else
        resultReg <= rawCode ^ adc_cfg_pkg::BIPOLAR_FLIP;
    end
  end

  // ==========================================================
  // Status and multiplexer outputs, all registered
  // Channels and coding move only with a start, never in
  // shutdown, so the multiplexer is quiet while powered down
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      convBusy     <= 1'b0;
      powerDown    <= 1'b0;
      posChannel   <= 4'h0;
      negChannel   <= 4'h1;
      unipolarMode <= 1'b0;
    end
    else
    begin
      convBusy  <= (stateReg == adc_cfg_pkg::ST_CONVERT);
      powerDown <= (stateReg == adc_cfg_pkg::ST_SHUTDOWN);
      if (donePulse && cfgNew[1:0] != adc_cfg_pkg::WL_DOWN)
      begin
        // Address fixed for the whole conversion
        posChannel   <= adc_cfg_pkg::mux_channel(cfgNew, 1'b0);
        negChannel   <= adc_cfg_pkg::mux_channel(cfgNew, 1'b1);
        unipolarMode <= cfgNew[adc_cfg_pkg::UNI_BIT];
      end
    end
  end

  // ==========================================================
  // Shift-clock engine
  // The engine resets on its own clock: the reset must span
  // at least one rising and one falling shift clock edge
  serial_shift_engine engine (
    .sclk    (sclk),
    .resetn  (resetn),
    .sdi     (sdi),
    .lnk     (lnk.link),
    .sdoLine (sdoLine)
  );

  // Data line: a flop of either domain, picked by the frame marker
  // Limitation: the line shows a value even when the enable
  // is low; the pad must gate it with the enable
  assign sdoOut = sdoLine;

endmodule : adc_serial_config_port

// ==== verification/adc_serial_config_port_monitor.sv ====
// Pin-level concurrent checks of the serial configuration port
module adc_serial_config_port_monitor (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic [11:0] rawCode,
  input  wire logic        sdoOut,
  input  wire logic        sdoOe,
  input  wire logic        convStart,
  input  wire logic        convBusy,
  input  wire logic [3:0]  posChannel,
  input  wire logic [3:0]  negChannel,
  input  wire logic        unipolarMode,
  input  wire logic        powerDown
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Helper counter
  logic [7:0] busyCnt_reg; // Busy cycles so far

  // Counts busy cycles, clears when idle
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      busyCnt_reg <= 8'h00;
    else if (convBusy)
      busyCnt_reg <= busyCnt_reg + 8'h01;
    else
      busyCnt_reg <= 8'h00;
  end

  // ==========================================================
  // Properties, all on the system clock
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  oe_rise_a: assert property ($rose(sdoOe) |-> !csN && !$past(csN) && !$past(csN, 2))
    else $error("output enabled without settled select");
  oe_fall_a: assert property ($fell(sdoOe) |-> csN && $past(csN))
    else $error("output released while select low");
  oe_idle_a: assert property (csN [*8] |-> !sdoOe)
    else $error("output driven with select high");
  busy_len_a: assert property ($fell(convBusy) |-> busyCnt_reg == 8'(adc_cfg_pkg::CONV_CYCLES))
    else $error("conversion length wrong");
  start_busy_a: assert property (convStart |=> convBusy && !convStart)
    else $error("start pulse not followed by busy");
  pd_quiet_a: assert property (powerDown |-> !convStart)
    else $error("conversion started in shutdown");
  pd_exit_a: assert property ($fell(powerDown) |-> !csN && !$past(csN, 2))
    else $error("shutdown left without select");
  chan_hold_a: assert property (($changed(posChannel) || $changed(negChannel)) |-> convStart || $past(convStart))
    else $error("channel changed outside start");
  pair_adj_a: assert property (negChannel != 4'h8 |-> (negChannel ^ posChannel) == 4'h1)
    else $error("differential pair not adjacent");
endmodule : adc_serial_config_port_monitor

bind adc_serial_config_port adc_serial_config_port_monitor mon_u (
  .clk_sys(clk_sys), .resetn(resetn), .csN(csN), .sclk(sclk), .sdi(sdi),
  .rawCode(rawCode), .sdoOut(sdoOut), .sdoOe(sdoOe), .convStart(convStart),
  .convBusy(convBusy), .posChannel(posChannel), .negChannel(negChannel),
  .unipolarMode(unipolarMode), .powerDown(powerDown)
);

// ==== verification/host_serial_model.sv ====
// Host side of the four-wire link: select, shift clock, data in
module host_serial_model (
  input  wire logic clk_sys,
  input  wire logic sdoOut,
  input  wire logic sdoOe,
  output logic      csN,
  output logic      sclk,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5; // Half of the 125 ns shift clock

  // Idle levels; shift clock stands still outside frames except in resetEdges and glitch
  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // A few edges so the shift-clock logic sees reset
  task automatic resetEdges();
    repeat (2)
    begin
      #(HALF) sclk = 1'b1;
      #(HALF) sclk = 1'b0;
    end
  endtask : resetEdges

  // One frame of nBits clocks; rx[k] is the k-th bit seen
  task automatic xfer(input logic [7:0] cfg, input int nBits, output logic [15:0] rx, output logic ok);
    int w;
    rx = 16'h0000;
    w = 0;
    @(posedge clk_sys) csN <= 1'b0;
    // No shifting until select is recognized
    while (sdoOe !== 1'b1 && w < 20)
    begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    ok = (sdoOe === 1'b1);
    for (int k = 0; k < nBits; k++)
    begin
      // Launch on falling edge, garbage after the word
      sdi = (k < 8) ? cfg[7 - k] : ~sdi;
      #(HALF) sclk = 1'b1;
      // A released line has no pull, so it reads as the inverse
      rx[k] = sdoOe ? sdoOut : ~sdoOut;
      #(HALF) sclk = 1'b0;
    end
    sdi = ~sdi;
    @(posedge clk_sys) csN <= 1'b1;
  endtask : xfer

  // One-cycle select glitch with clocks while deselected
  task automatic glitch();
    @(posedge clk_sys) csN <= 1'b0;
    @(posedge clk_sys) csN <= 1'b1;
    repeat (4)
    begin
      #(HALF) sclk = 1'b1;
      sdi = ~sdi;
      #(HALF) sclk = 1'b0;
    end
  endtask : glitch
endmodule : host_serial_model

// ==== verification/adc_serial_config_port_tb.sv ====
// Self-checking bench of the serial configuration port
module adc_serial_config_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals and bookkeeping
  logic        clk_sys, resetn, csN, sclk, sdi, sdoOut, sdoOe;
  logic        convStart, convBusy, unipolarMode, powerDown;
  logic [11:0] rawCode;
  logic [3:0]  posChannel, negChannel;
  logic [11:0] heldRes;  // Result the next frame must carry
  logic        heldMsbf; // Its output order
  int          errCount, checked, cycles;
  int unsigned seedV;

  adc_serial_config_port dut_u (.clk_sys(clk_sys), .resetn(resetn), .csN(csN), .sclk(sclk),
    .sdi(sdi), .rawCode(rawCode), .sdoOut(sdoOut), .sdoOe(sdoOe), .convStart(convStart),
    .convBusy(convBusy), .posChannel(posChannel), .negChannel(negChannel),
    .unipolarMode(unipolarMode), .powerDown(powerDown));
  host_serial_model host_u (.clk_sys(clk_sys), .sdoOut(sdoOut), .sdoOe(sdoOe), .csN(csN),
    .sclk(sclk), .sdi(sdi));

  // 10 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the planned run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 12000)
    begin
      errCount++;
      completeRun();
    end
  end

  // ==========================================================
  // Expectation helpers
  function automatic logic [4:0] lenOf(input logic [1:0] wl);
    case (wl)
      2'h0: return 5'h08;
      2'h1: return 5'h0A;
      2'h2: return 5'h0C;
      default: return 5'h10;
    endcase
  endfunction : lenOf

  // Serial image: k-th bit sent, zeros past twelve
  function automatic logic [15:0] expRx(input logic [11:0] r, input logic m, input logic [4:0] n);
    logic [15:0] v;
    v = 16'h0000;
    for (int k = 0; k < 12; k++)
      if (k < n)
        v[k] = m ? r[11 - k] : r[k];
    return v;
  endfunction : expRx

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Watch n cycles: no start, optionally no enable
  task automatic noWake(input int n, input logic oeToo);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
      seen = seen | convStart | (oeToo & sdoOe);
    end
    check({15'h0, seen}, 16'h0000);
  endtask : noWake

  // One full frame with conversion or shutdown
  task automatic doFrame(input logic [7:0] c, input logic [11:0] raw);
    logic [15:0] rx;
    logic        ok;
    logic [4:0]  n;
    int          w;
    n = lenOf(c[1:0]);
    @(posedge clk_sys) rawCode <= raw;
    host_u.xfer(c, n, rx, ok);
    check({15'h0, ok}, 16'h0001);
    check(rx, expRx(heldRes, heldMsbf, n));
    if (c[1:0] == 2'h1)
    begin
      noWake(20, 1'b0);
      check({15'h0, powerDown}, 16'h0001);
    end
    else
    begin
      check({15'h0, powerDown}, 16'h0000);
      w = 0;
      while (convStart !== 1'b1 && w < 30)
      begin
        @(posedge clk_sys);
        #1;
        w++;
      end
      check({15'h0, convStart}, 16'h0001);
      @(posedge clk_sys);
      #1;
      check({7'h0, posChannel, negChannel, unipolarMode},
            {7'h0, 1'b0, c[5:4], c[6], c[7] ? 4'h8 : {1'b0, c[5:4], ~c[6]}, c[3]});
      w = 0;
      while (convBusy !== 1'b0 && w < 200)
      begin
        @(posedge clk_sys);
        #1;
        w++;
      end
      check({15'h0, convBusy}, 16'h0000);
      heldRes = c[3] ? raw : raw ^ 12'h800;
      heldMsbf = c[2];
    end
    $display("frame cfg=%h done", c);
  endtask : doFrame

  task automatic completeRun();
    $display("checks=%0d mismatches=%0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : completeRun

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [1:0]  wlTab [3];
    logic [15:0] rx;
    logic        ok;
    wlTab = '{2'h0, 2'h2, 2'h3};
    resetn = 1'b0;
    rawCode = 12'h000;
    errCount = 0;
    checked = 0;
    cycles = 0;
    heldRes = 12'h000;
    heldMsbf = 1'b0;
    seedV = $urandom(32'hCBC4);
    host_u.resetEdges();
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    // Every multiplexer address, random coding and order
    for (int i = 0; i < 16; i++)
      doFrame({4'(i), 1'($urandom), 1'($urandom), wlTab[i % 3]}, 12'($urandom));
    // Full-scale and boundary codes, then a shutdown frame
    doFrame(8'hFF, 12'hFFF);
    doFrame(8'h03, 12'h000);
    doFrame(8'hE6, 12'h7FF);
    doFrame(8'h0E, 12'h001);
    doFrame({4'h0, 1'b1, heldMsbf, 2'h1}, 12'h5A5);
    // Abandoned frame, then a glitch: nothing may start
    host_u.xfer(8'h8E, 3, rx, ok);
    noWake(30, 1'b0);
    check({15'h0, powerDown}, 16'h0000);
    host_u.glitch();
    noWake(20, 1'b1);
    $display("abandon and glitch tests done");
    doFrame(8'h4A, 12'h3C3);
    doFrame(8'h2E, 12'h000);
    completeRun();
  end
endmodule : adc_serial_config_port_tb
